// ### src/irs_pkg.sv
// irs_pkg: shared constants and carrier types for the interrupt return,
// software trap and external interrupt block.
// assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package irs_pkg;

    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [7:0] IDX_EXT_CTRL = 8'h37;
    localparam logic [7:0] IDX_CTRL = 8'h38;
    localparam logic [7:0] IDX_STATUS = 8'h39;
    localparam logic [7:0] IDX_SP = 8'h3A;
    localparam logic [7:0] IDX_INT_STAT = 8'h3B;
    localparam logic [7:0] IDX_INT_CLR = 8'h3C;
    localparam logic [7:0] IDX_INT_EN = 8'h3D;
    localparam int APB_AW = 12;

    // ==========================================================
    // field positions and reset values
    localparam int EXT_PIN_SEL_BIT = 6;
    localparam logic [7:0] EXT_CTRL_RST = 8'h00;
    localparam int CTRL_IMF_BIT = 0;
    localparam int CTRL_EF_BIT = 1;
    localparam int CTRL_DIV_BIT = 2;
    localparam int CTRL_LATCH_BIT = 3;
    localparam int ST_NMI_ACT_BIT = 0;
    localparam int ST_NEST_FLAG_BIT = 1;
    localparam int ST_PIN_LVL_BIT = 2;
    localparam int ST_NEST_LSB = 4;
    localparam int EV_ACCEPT_BIT = 0;
    localparam int EV_SWI_BIT = 1;
    localparam int EV_TRAP_BIT = 2;
    localparam int EV_EXT_BIT = 3;
    localparam int EV_W = 4;
    localparam int NEST_W = 4;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] SP_STEP = 16'h0005;
    localparam logic [7:0] TRAP_OPCODE = 8'hFF;

    // ==========================================================
    // memory regions that must never hold code
    localparam logic [15:0] SFR_LO = 16'h0000;
    localparam logic [15:0] SFR_HI = 16'h003F;
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h023F;
    localparam logic [15:0] DBR_LO = 16'h1F80;
    localparam logic [15:0] DBR_HI = 16'h1FFF;

    // ==========================================================
    // noise filter timing, in high-frequency clock periods
    localparam int FILT_REJECT_CYC = 2;
    localparam int FILT_PASS_CYC = 6;
    localparam int FILT_LEN = (FILT_REJECT_CYC + FILT_PASS_CYC) / 2;
    localparam int FILT_CW = 3;

    // ==========================================================
    // carriers
    typedef enum logic [1:0] {SRC_NONE, SRC_SWI, SRC_NMI, SRC_EXT0} irs_src_t;

    typedef struct packed {
        logic last;
        logic maskable_return_op;
        logic nonmaskable_return_op;
        logic soft_trap_op;
        logic nmi_req;
    } irs_core_evt_t;

    typedef struct packed {
        logic valid;
        logic present;
        logic [15:0] addr;
        logic [7:0] data;
    } irs_fetch_t;

endpackage : irs_pkg

// ### src/irs_sync2.sv
// irs_sync2: two-stage synchroniser for one asynchronous level.
// assumes the input may change at any time relative to clk.
`timescale 1ns/1ns
module irs_sync2 (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);
    logic meta_reg;

    // ==========================================================
    // resets high: idle level of a falling-edge input
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule : irs_sync2

// ### src/irs_noise_filter.sv
// irs_noise_filter: counter based digital noise filter.
// assumes din is already synchronised; tick paces the sampling.
`timescale 1ns/1ns
module irs_noise_filter (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic tick, // sample enable
    input wire logic din, // synchronised input level
    output logic dout // filtered level
);
    import irs_pkg::*;

    logic [FILT_CW-1:0] cnt_reg;

    // ==========================================================
    // level must persist FILT_LEN samples before it is passed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            dout <= 1'b1;
        end else if (din == dout) begin
            cnt_reg <= '0;
        end else if (tick) begin
            if (cnt_reg == FILT_CW'(FILT_LEN - 1)) begin
                dout <= din;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + FILT_CW'(1);
            end
        end
    end

    AST_FILT_REJECT: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(dout) |-> ($past(din) == dout) && ($past(din, 2) == dout))
        else $error("filter passed a pulse shorter than two samples");
endmodule : irs_noise_filter

// ### src/irs_irq_ctrl.sv
// irs_irq_ctrl: interrupt return, software trap and external interrupt.
// assumes the core reports instruction events on CLK and polls PREADY.
`timescale 1ns/1ns
// Functional notes
// - either return restores PC and status word, stack pointer up five
// - maskable return sets master enable to one
// - non-maskable return restores enable only if it was set and not cleared
// - both returns decrement nesting counter and update nesting flag
// - pending requests sampled in each instruction's last cycle
// - trap opcode raises software interrupt at once, highest priority
// - trap opcode is a no-operation while non-maskable service runs
// - fetch from absent address in single-chip mode returns FFH
// - fetch from RAM, data buffer or special register region resets
// - reset leaves the shared pin as an ordinary port input
// - falling edge sets latch only when pin select is one
// - filter drops pulses under 2 clocks, passes 6 or more with divider select clear, 8 or more with it set
// - acceptance clears enable, pushes, stack pointer down five; only external acceptance clears latch
// - a set latch stays pending until accepted or cleared
module irs_irq_ctrl
    import irs_pkg::*;
(
    input wire logic CLK, // system clock, 50 MHz
    input wire logic RST_B, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [irs_pkg::APB_AW-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    input wire irs_pkg::irs_core_evt_t CORE_EVT, // core instruction events
    input wire irs_pkg::irs_fetch_t FETCH, // opcode fetch request
    input wire logic SINGLE_CHIP, // single-chip mode
    input wire logic EXT0_IRQ_INPUT, // shared external pin, async
    output logic MASTER_IRQ_ENABLE, // master enable flag
    output logic [15:0] SP_O, // stack pointer
    output logic [irs_pkg::NEST_W-1:0] NEST_CNT_O, // nesting counter
    output logic NEST_FLAG_O, // nesting flag
    output logic ACCEPT_O, // acceptance pulse, push now
    output irs_pkg::irs_src_t ACCEPT_SRC_O, // accepted source
    output logic RESTORE_O, // return pulse, pop PC and status word
    output logic [7:0] OPCODE_O, // fetched opcode to core
    output logic ADDR_TRAP_RST_O, // address trap reset pulse
    output logic PORT1_BIT_ZERO, // pin level as port input
    output logic IRQ // event interrupt, level
);
    import irs_pkg::*;

    // ==========================================================
    // state
    logic [7:0] ext_ctrl_reg;
    logic ext0_irq_enable_reg;
    logic div_sel_reg;
    logic ext0_irq_latch_reg;
    logic nmi_pend_reg;
    logic nmi_active_reg;
    logic nmi_imf_saved_reg;
    logic [EV_W-1:0] int_stat_reg;
    logic [EV_W-1:0] int_en_reg;
    logic tick_reg;
    logic filt_prev_reg;
    logic pin_sync;
    logic pin_filt;
    logic [15:0] sp_next;
    logic [NEST_W-1:0] nest_next;
    logic imf_next;

    // ==========================================================
    // apb decode
    logic apb_acc;
    logic apb_wr;
    logic [7:0] idx;
    logic hit_ext, hit_ctrl, hit_status, hit_sp, hit_stat, hit_clr, hit_en;
    logic mapped;

    assign apb_acc = PSEL & PENABLE & PREADY;
    assign apb_wr = apb_acc & PWRITE;
    assign idx = PADDR[9:2];

    always_comb begin
        hit_ext = 1'b0;
        hit_ctrl = 1'b0;
        hit_status = 1'b0;
        hit_sp = 1'b0;
        hit_stat = 1'b0;
        hit_clr = 1'b0;
        hit_en = 1'b0;
        if (PADDR[APB_AW-1:10] != '0 || PADDR[1:0] != 2'b00) begin
            hit_ext = 1'b0;
        end else if (idx == IDX_EXT_CTRL) begin
            hit_ext = 1'b1;
        end else if (idx == IDX_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (idx == IDX_STATUS) begin
            hit_status = 1'b1;
        end else if (idx == IDX_SP) begin
            hit_sp = 1'b1;
        end else if (idx == IDX_INT_STAT) begin
            hit_stat = 1'b1;
        end else if (idx == IDX_INT_CLR) begin
            hit_clr = 1'b1;
        end else if (idx == IDX_INT_EN) begin
            hit_en = 1'b1;
        end
    end

    assign mapped = hit_ext | hit_ctrl | hit_status | hit_sp | hit_stat | hit_clr | hit_en;

    // ==========================================================
    // core events and acceptance
    logic ret_any;
    logic imf_eff;
    logic swi_take, nmi_take, ext_take, any_take;
    logic swi_nop;
    logic pin_sel;
    logic ext_fall;

    assign pin_sel = ext_ctrl_reg[EXT_PIN_SEL_BIT];
    assign ret_any = CORE_EVT.last & (CORE_EVT.maskable_return_op | CORE_EVT.nonmaskable_return_op);

    // enable as it stands after a return ending in this same cycle
    always_comb begin
        imf_eff = MASTER_IRQ_ENABLE;
        if (CORE_EVT.last && CORE_EVT.maskable_return_op) begin
            imf_eff = 1'b1;
        end else if (CORE_EVT.last && CORE_EVT.nonmaskable_return_op) begin
            imf_eff = nmi_imf_saved_reg;
        end
    end

    assign swi_take = CORE_EVT.last & CORE_EVT.soft_trap_op & ~nmi_active_reg;
    assign swi_nop = CORE_EVT.last & CORE_EVT.soft_trap_op & nmi_active_reg;
    assign nmi_take = CORE_EVT.last & ~swi_take & nmi_pend_reg;
    assign ext_take = CORE_EVT.last & ~swi_take & ~nmi_take & ext0_irq_latch_reg
                      & imf_eff & ext0_irq_enable_reg & pin_sel;
    assign any_take = swi_take | nmi_take | ext_take;
    assign ext_fall = filt_prev_reg & ~pin_filt;

    // ==========================================================
    // stack pointer
    always_comb begin
        sp_next = SP_O;
        if (ret_any) begin
            sp_next = sp_next + SP_STEP;
        end
        if (any_take) begin
            sp_next = sp_next - SP_STEP;
        end
        if (!ret_any && !any_take && apb_wr && hit_sp) begin
            sp_next = PWDATA[15:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SP_O <= SP_RST;
        end else begin
            SP_O <= sp_next;
        end
    end

    // ==========================================================
    // nesting counter and flag
    always_comb begin
        nest_next = NEST_CNT_O;
        if (ret_any && NEST_CNT_O != '0) begin
            nest_next = nest_next - NEST_W'(1);
        end
        if (any_take) begin
            nest_next = nest_next + NEST_W'(1);
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            NEST_CNT_O <= '0;
            NEST_FLAG_O <= 1'b0;
        end else begin
            NEST_CNT_O <= nest_next;
            NEST_FLAG_O <= (nest_next != '0);
        end
    end

    // ==========================================================
    // master enable; hardware wins over a software write
    always_comb begin
        imf_next = MASTER_IRQ_ENABLE;
        if (apb_wr && hit_ctrl) begin
            imf_next = PWDATA[CTRL_IMF_BIT];
        end
        if (ret_any) begin
            imf_next = imf_eff;
        end
        if (any_take) begin
            imf_next = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            MASTER_IRQ_ENABLE <= 1'b0;
        end else begin
            MASTER_IRQ_ENABLE <= imf_next;
        end
    end

    // ==========================================================
    // non-maskable tracking
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            nmi_pend_reg <= 1'b0;
            nmi_active_reg <= 1'b0;
            nmi_imf_saved_reg <= 1'b0;
        end else begin
            if (CORE_EVT.nmi_req) begin
                nmi_pend_reg <= 1'b1;
            end else if (nmi_take) begin
                nmi_pend_reg <= 1'b0;
            end
            if (nmi_take) begin
                nmi_active_reg <= 1'b1;
                nmi_imf_saved_reg <= imf_eff;
            end else if (CORE_EVT.last && CORE_EVT.nonmaskable_return_op) begin
                nmi_active_reg <= 1'b0;
            end else if (nmi_active_reg && apb_wr && hit_ctrl && !PWDATA[CTRL_IMF_BIT]) begin
                nmi_imf_saved_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // acceptance and return strobes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACCEPT_O <= 1'b0;
            ACCEPT_SRC_O <= SRC_NONE;
            RESTORE_O <= 1'b0;
        end else begin
            ACCEPT_O <= any_take;
            RESTORE_O <= ret_any;
            if (swi_take) begin
                ACCEPT_SRC_O <= SRC_SWI;
            end else if (nmi_take) begin
                ACCEPT_SRC_O <= SRC_NMI;
            end else if (ext_take) begin
                ACCEPT_SRC_O <= SRC_EXT0;
            end else begin
                ACCEPT_SRC_O <= SRC_NONE;
            end
        end
    end

    // ==========================================================
    // opcode fetch: absent memory reads as trap in single-chip mode, regions that must never hold code trap-reset
    logic in_code_trap;

    assign in_code_trap = (FETCH.addr <= SFR_HI)
                          | (FETCH.addr >= RAM_LO && FETCH.addr <= RAM_HI)
                          | (FETCH.addr >= DBR_LO && FETCH.addr <= DBR_HI);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            OPCODE_O <= TRAP_OPCODE;
            ADDR_TRAP_RST_O <= 1'b0;
        end else begin
            if (FETCH.valid) begin
                OPCODE_O <= (SINGLE_CHIP && !FETCH.present) ? TRAP_OPCODE : FETCH.data;
            end
            ADDR_TRAP_RST_O <= FETCH.valid & in_code_trap;
        end
    end

    // ==========================================================
    // external pin: synchronise, filter, edge
    irs_sync2 u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .din(EXT0_IRQ_INPUT),
        .dout(pin_sync)
    );

    irs_noise_filter u_filt (
        .clk(CLK),
        .rst_b(RST_B),
        .tick(tick_reg),
        .din(pin_sync),
        .dout(pin_filt)
    );

    // divider select halves the sampling rate
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_reg <= 1'b1;
            filt_prev_reg <= 1'b1;
            PORT1_BIT_ZERO <= 1'b1;
        end else begin
            tick_reg <= div_sel_reg ? ~tick_reg : 1'b1;
            filt_prev_reg <= pin_filt;
            PORT1_BIT_ZERO <= pin_sync;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext_ctrl_reg <= EXT_CTRL_RST;
            ext0_irq_enable_reg <= 1'b0;
            div_sel_reg <= 1'b0;
            int_en_reg <= '0;
        end else if (apb_wr) begin
            if (hit_ext) begin
                ext_ctrl_reg <= PWDATA[7:0];
            end else if (hit_ctrl) begin
                ext0_irq_enable_reg <= PWDATA[CTRL_EF_BIT];
                div_sel_reg <= PWDATA[CTRL_DIV_BIT];
            end else if (hit_en) begin
                int_en_reg <= PWDATA[EV_W-1:0];
            end
        end
    end

    // latch: set wins over any clear
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext0_irq_latch_reg <= 1'b0;
        end else if (ext_fall && pin_sel) begin
            ext0_irq_latch_reg <= 1'b1;
        end else if (ext_take) begin
            ext0_irq_latch_reg <= 1'b0;
        end else if (apb_wr && hit_ctrl) begin
            ext0_irq_latch_reg <= PWDATA[CTRL_LATCH_BIT];
        end
    end

    // ==========================================================
    // event status, enable, interrupt output
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    always_comb begin
        ev_set = '0;
        ev_set[EV_ACCEPT_BIT] = any_take;
        ev_set[EV_SWI_BIT] = swi_take;
        ev_set[EV_TRAP_BIT] = FETCH.valid & in_code_trap;
        ev_set[EV_EXT_BIT] = ext_fall & pin_sel;
        ev_clr = (apb_wr && hit_clr) ? PWDATA[EV_W-1:0] : '0;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            int_stat_reg <= '0;
            IRQ <= 1'b0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~ev_clr) | ev_set;
            IRQ <= |(((int_stat_reg & ~ev_clr) | ev_set) & int_en_reg);
        end
    end

    // ==========================================================
    // apb answer: one wait state
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hit_ext) begin
            rd_mux[7:0] = ext_ctrl_reg;
        end else if (hit_ctrl) begin
            rd_mux[CTRL_IMF_BIT] = MASTER_IRQ_ENABLE;
            rd_mux[CTRL_EF_BIT] = ext0_irq_enable_reg;
            rd_mux[CTRL_DIV_BIT] = div_sel_reg;
            rd_mux[CTRL_LATCH_BIT] = ext0_irq_latch_reg;
        end else if (hit_status) begin
            rd_mux[ST_NMI_ACT_BIT] = nmi_active_reg;
            rd_mux[ST_NEST_FLAG_BIT] = NEST_FLAG_O;
            rd_mux[ST_PIN_LVL_BIT] = PORT1_BIT_ZERO;
            rd_mux[ST_NEST_LSB +: NEST_W] = NEST_CNT_O;
        end else if (hit_sp) begin
            rd_mux[15:0] = SP_O;
        end else if (hit_stat) begin
            rd_mux[EV_W-1:0] = int_stat_reg;
        end else if (hit_en) begin
            rd_mux[EV_W-1:0] = int_en_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_mux : '0;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
        end
    end

    // ==========================================================
    // checks
    logic solo_maskable_return_op, solo_nonmaskable_return_op;
    assign solo_maskable_return_op = CORE_EVT.last & CORE_EVT.maskable_return_op & ~any_take;
    assign solo_nonmaskable_return_op = CORE_EVT.last & CORE_EVT.nonmaskable_return_op & ~any_take;

    AST_RET_SP: assert property (@(posedge CLK) disable iff (!RST_B)
        (solo_maskable_return_op || solo_nonmaskable_return_op) |=> SP_O == $past(SP_O) + SP_STEP && RESTORE_O)
        else $error("return did not raise stack pointer by five");
    AST_MASKABLE_RETURN_OP_IMF: assert property (@(posedge CLK) disable iff (!RST_B)
        solo_maskable_return_op |=> MASTER_IRQ_ENABLE)
        else $error("maskable return left master enable clear");
    AST_NONMASKABLE_RETURN_OP_IMF: assert property (@(posedge CLK) disable iff (!RST_B)
        solo_nonmaskable_return_op |=> MASTER_IRQ_ENABLE == $past(nmi_imf_saved_reg))
        else $error("non-maskable return restored wrong enable");
    AST_RET_NEST: assert property (@(posedge CLK) disable iff (!RST_B)
        ((solo_maskable_return_op || solo_nonmaskable_return_op) && NEST_CNT_O != '0)
        |=> NEST_CNT_O == $past(NEST_CNT_O) - NEST_W'(1) && NEST_FLAG_O == (NEST_CNT_O != '0))
        else $error("return did not decrement nesting");
    AST_SWI_TAKE: assert property (@(posedge CLK) disable iff (!RST_B)
        (CORE_EVT.last && CORE_EVT.soft_trap_op && !nmi_active_reg)
        |=> ACCEPT_O && ACCEPT_SRC_O == SRC_SWI)
        else $error("trap opcode not accepted at once");
    AST_SWI_NOP: assert property (@(posedge CLK) disable iff (!RST_B)
        swi_nop |=> ACCEPT_SRC_O != SRC_SWI)
        else $error("trap raised during non-maskable service");
    AST_FETCH_FF: assert property (@(posedge CLK) disable iff (!RST_B)
        (FETCH.valid && SINGLE_CHIP && !FETCH.present) |=> OPCODE_O == TRAP_OPCODE)
        else $error("absent fetch did not return trap opcode");
    AST_ADDR_TRAP: assert property (@(posedge CLK) disable iff (!RST_B)
        (FETCH.valid && FETCH.addr >= DBR_LO && FETCH.addr <= DBR_HI) |=> ADDR_TRAP_RST_O)
        else $error("fetch from data buffer did not trap");
    AST_PIN_GATE: assert property (@(posedge CLK) disable iff (!RST_B)
        (!pin_sel && !ext0_irq_latch_reg && !(apb_wr && hit_ctrl)) |=> !ext0_irq_latch_reg)
        else $error("latch set while pin in port mode");
    AST_ACCEPT: assert property (@(posedge CLK) disable iff (!RST_B)
        (any_take && !ret_any) |=> !MASTER_IRQ_ENABLE && SP_O == $past(SP_O) - SP_STEP)
        else $error("acceptance did not clear enable and push five");
    AST_LATCH_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
        (ext0_irq_latch_reg && !ext_take && !(apb_wr && hit_ctrl)) |=> ext0_irq_latch_reg)
        else $error("pending latch lost");
endmodule : irs_irq_ctrl

// ### verif/irs_pin_src.sv
// irs_pin_src: external source on the shared interrupt pin
// assumes the bench requests one low pulse at a time; idles high
`timescale 1ns/1ns
module irs_pin_src (
    input wire logic clk, // system clock
    input wire logic [3:0] low_len, // low pulse cycles, 0 idle
    output logic pin // pin level
);
    int n = 0;
    initial pin = 1'b1;
    // pin is never driven as an output, so no spurious edges
    always @(posedge clk) begin
        if (n > 0) begin
            pin <= (n == 1);
            n <= n - 1;
        end else if (low_len != 0) begin
            pin <= 1'b0;
            n <= low_len;
        end
    end
endmodule : irs_pin_src

// ### verif/tb.sv
// tb: self-checking bench for irs_irq_ctrl
// assumes irs_pin_src stands on the shared pin
`timescale 1ns/1ns
module tb;
    import irs_pkg::*;
    logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, sc = 1, ready, err;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prd, rd;
    logic mie, acc, res, nf, trp, p1, irq, pin, slv;
    logic [3:0] nc, plen = '0;
    logic [15:0] spo, a;
    logic [7:0] op;
    irs_core_evt_t ev = '0;
    irs_fetch_t fe = '0;
    irs_src_t src;
    int err_total = 0, samples_checked = 0, seed = 34442, sp;
    always #10 clk = ~clk;
    irs_pin_src src_m (.clk(clk), .low_len(plen), .pin(pin));
    irs_irq_ctrl DUT (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(ready), .PSLVERR(err),
        .CORE_EVT(ev), .FETCH(fe), .SINGLE_CHIP(sc), .EXT0_IRQ_INPUT(pin),
        .MASTER_IRQ_ENABLE(mie), .SP_O(spo), .NEST_CNT_O(nc), .NEST_FLAG_O(nf),
        .ACCEPT_O(acc), .ACCEPT_SRC_O(src), .RESTORE_O(res), .OPCODE_O(op),
        .ADDR_TRAP_RST_O(trp), .PORT1_BIT_ZERO(p1), .IRQ(irq));
    // ==========================================================
    // tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1; pwr <= w; pa <= ad; pwd <= d;
        @(posedge clk);
        pen <= 1;
        // waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (ready !== 1'b1);
        rd = prd;
        slv = err;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb
    task go(input logic [4:0] e, input logic [25:0] f);
        ev <= e;
        fe <= f;
        @(posedge clk);
        ev <= '0;
        fe <= '0;
        @(posedge clk);
    endtask : go
    task pin_try(input logic sel, input logic [3:0] len, input logic [31:0] e);
        apb(1, 12'h0E0, 32'h0);
        apb(1, 12'h0DC, {25'h0, sel, 6'h00});
        apb(1, 12'h0E0, 32'h2);
        plen <= len;
        @(posedge clk);
        plen <= '0;
        repeat (24) @(posedge clk);
        apb(0, 12'h0E0, 0);
        chk(rd, e);
    endtask : pin_try
    task final_report;
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        err_total++;
        final_report;
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        chk(p1, 1);
        apb(0, 12'h0DC, 0); chk(rd, 0);
        apb(0, 12'h100, 0); chk(slv, 1);
        sp = $random(seed) & 16'hFFFF;
        apb(1, 12'h0E8, sp); apb(1, 12'h0E0, 0); apb(1, 12'h0F4, 32'hF);
        go(5'b10010, '0); chk(acc, 1); chk(src, SRC_SWI);
        sp = (sp - 5) & 16'hFFFF;
        chk(spo, sp); chk(mie, 0); chk(nc, 1);
        go(5'b11000, '0); chk(res, 1); chk(mie, 1);
        sp = (sp + 5) & 16'hFFFF;
        chk(spo, sp); chk({nc, nf}, 0);
        go(5'b00001, '0); go(5'b10000, '0); chk(src, SRC_NMI); chk(mie, 0);
        go(5'b10010, '0); chk(acc, 0);
        go(5'b10100, '0); chk(mie, 1); chk(spo, sp);
        go(5'b00001, '0); go(5'b10000, '0); chk(src, SRC_NMI);
        apb(1, 12'h0E0, 0); go(5'b10100, '0); chk(mie, 0); chk(spo, sp);
        go(0, {2'b11, 16'hC000, 8'h5A}); chk(op, 8'h5A); chk(trp, 0);
        go(0, {2'b10, 16'h8000, 8'h00}); chk(op, 8'hFF);
        sc <= 0; go(0, {2'b10, 16'h8000, 8'h3C}); chk(op, 8'h3C); sc <= 1;
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 16'h0010 : (i == 1) ? 16'h0100 : 16'h1F90;
            go(0, {2'b11, a, 8'h00}); chk(trp, 1);
        end
        apb(0, 12'h0EC, 0); chk(rd, 7); chk(irq, 1);
        apb(1, 12'h0F0, 32'hF); apb(0, 12'h0EC, 0); chk(rd, 0); chk(irq, 0);
        pin_try(1, 1, 32'h2);
        pin_try(1, 6, 32'hA);
        apb(1, 12'h0E0, 32'hB); go(5'b10000, '0); chk(acc, 1); chk(src, SRC_EXT0);
        chk(mie, 0); apb(0, 12'h0E0, 0); chk(rd, 2);
        pin_try(0, 8, 32'h2);
        final_report;
    end
endmodule : tb
